//--- hdl/itsm_top.sv
// What this block does
// - A masked terminal follows only its internal state, never its wire.
// - Terminals one-seven sit on bits zero-six, ten-twelve on ten-twelve.
// - The internal-state word gives each internally sourced terminal's state.
// - Keypad writes to the internal-state word lose against every other writer.
// - A controller-owned terminal can still be activated by its virtual bit.
// - Polarity bit zero reads virtual terminals normally open, one closed.
// - Mask and internal-state words are saved and restored over power loss.
// - Both words are 16-bit, take any pattern, and default to zero.
//
// Register access over Wishbone was left to the implementer.
module itsm_top
  import itsm_pkg::*;
(
  input  wire logic                   clk_i,        // System clock, 10 MHz.
  input  wire logic                   rst_i,        // Synchronous reset.
  input  wire logic [ITSM_AW-1:0]     wb_adr_i,     // Wishbone byte address.
  input  wire logic [ITSM_BUS_DW-1:0] wb_dat_i,     // Wishbone write data.
  input  wire logic [3:0]             wb_sel_i,     // Wishbone byte enables.
  input  wire logic                   wb_we_i,      // Wishbone write enable.
  input  wire logic                   wb_cyc_i,     // Wishbone cycle.
  input  wire logic                   wb_stb_i,     // Wishbone strobe.
  output logic                        wb_ack_o,     // Wishbone acknowledge.
  output logic [ITSM_BUS_DW-1:0]      wb_dat_o,     // Wishbone read data.
  input  wire logic [ITSM_DW-1:0]     mfi_wire_i,   // Physical terminal levels.
  input  itsm_req_t                   comm_req_i,   // Comm card state write.
  input  itsm_req_t                   keypad_req_i, // Keypad state write.
  input  wire logic [ITSM_DW-1:0]     ctrl_own_i,   // Controller owns terminal.
  input  wire logic [ITSM_DW-1:0]     ctrl_level_i, // Controller terminal level.
  input  wire logic                   nv_ready_i,   // Retained words valid.
  input  itsm_words_t                 nv_words_i,   // Retained words.
  output logic                        nv_save_o,    // Save pulse to storage.
  output itsm_words_t                 nv_words_o,   // Words to store.
  output logic [ITSM_DW-1:0]          mfi_state_o   // Resolved terminal states.
);

  // Bus side of the register file.
  logic [15:0]             reg_idx;
  logic                    reg_wr;
  logic [ITSM_DW-1:0]      reg_wdat;
  logic [ITSM_LANES-1:0]   reg_sel;
  logic [ITSM_DW-1:0]      rd_word;

  // Retention handshake.
  logic                    restore;
  itsm_words_t             load_words;
  itsm_words_t             cur_words;

  // Register state.
  logic [ITSM_DW-1:0]      mask_q;
  logic [ITSM_DW-1:0]      mask_d;
  logic [ITSM_DW-1:0]      state_q;
  logic [ITSM_DW-1:0]      state_d;
  logic [ITSM_DW-1:0]      pol_q;
  logic [ITSM_DW-1:0]      pol_d;

  // Terminal path state.
  logic [ITSM_DW-1:0]      sync1_q;
  logic [ITSM_DW-1:0]      sync1_d;
  logic [ITSM_DW-1:0]      sync2_q;
  logic [ITSM_DW-1:0]      sync2_d;
  logic [ITSM_DW-1:0]      res_q;
  logic [ITSM_DW-1:0]      res_d;
  logic [ITSM_DW-1:0]      virt;
  logic [ITSM_DW-1:0]      resolved;

  itsm_wb_slave u_wb (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wb_adr_i   (wb_adr_i),
    .wb_dat_i   (wb_dat_i),
    .wb_sel_i   (wb_sel_i),
    .wb_we_i    (wb_we_i),
    .wb_cyc_i   (wb_cyc_i),
    .wb_stb_i   (wb_stb_i),
    .wb_ack_o   (wb_ack_o),
    .wb_dat_o   (wb_dat_o),
    .rd_word_i  (rd_word),
    .reg_idx_o  (reg_idx),
    .reg_wr_o   (reg_wr),
    .reg_wdat_o (reg_wdat),
    .reg_sel_o  (reg_sel)
  );

  assign cur_words.mask  = mask_q;
  assign cur_words.state = state_q;

  // Every change of either word after the restore is pushed to storage.
  itsm_nvstore u_nv (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .nv_ready_i   (nv_ready_i),
    .nv_words_i   (nv_words_i),
    .cur_words_i  (cur_words),
    .restore_o    (restore),
    .load_words_o (load_words),
    .nv_save_o    (nv_save_o),
    .nv_words_o   (nv_words_o)
  );

  // Read decode; unmapped indices read as zero.
  always_comb
  begin
    unique case (reg_idx)
      ITSM_IDX_MASK:  rd_word = mask_q;
      ITSM_IDX_STATE: rd_word = state_q;
      ITSM_IDX_POL:   rd_word = pol_q;
      ITSM_IDX_RES:   rd_word = res_q;
      ITSM_IDX_WIRE:  rd_word = sync2_q & ITSM_USED_BITS;
      default:        rd_word = ITSM_RST_WORD;
    endcase
  end

  // Register file next values. Writes are taken at any time, including
  // while the motor runs; the block has no run interlock.
  always_comb
  begin
    mask_d  = mask_q;
    state_d = state_q;
    pol_d   = pol_q;
    // The keypad is applied first so every other writer overrides it.
    if (keypad_req_i.wr)
    begin
      state_d = keypad_req_i.data;
    end
    if (comm_req_i.wr)
    begin
      state_d = comm_req_i.data;
    end
    if (reg_wr)
    begin
      // All bits of the enabled byte lanes are stored; unused bits simply have no effect.
      unique case (reg_idx)
        ITSM_IDX_MASK:  mask_d  = itsm_merge(mask_q, reg_wdat, reg_sel);
        ITSM_IDX_STATE: state_d = itsm_merge(state_q, reg_wdat, reg_sel);
        ITSM_IDX_POL:   pol_d   = itsm_merge(pol_q, reg_wdat, reg_sel);
        default:        mask_d  = mask_q;
      endcase
    end
    // Restored words win: they describe the state before power was lost.
    if (restore)
    begin
      mask_d  = load_words.mask;
      state_d = load_words.state;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_q  <= ITSM_RST_WORD;
      state_q <= ITSM_RST_WORD;
      pol_q   <= ITSM_RST_WORD;
    end
    else
    begin
      mask_q  <= mask_d;
      state_q <= state_d;
      pol_q   <= pol_d;
    end
  end

  // Normally closed virtual terminals are active while their bit is clear.
  assign virt = state_q ^ pol_q;

  // Per-terminal source select; bits without a terminal stay inactive.
  genvar g;
  generate
    for (g = 0; g < ITSM_DW; g++)
    begin : g_sel
      assign resolved[g] = ITSM_USED_BITS[g] &
        (mask_q[g] ? virt[g] :
        (ctrl_own_i[g] ? (ctrl_level_i[g] | virt[g]) :
        sync2_q[g]));
    end
  endgenerate

  // Terminal path next values; the first stage feeds only the second.
  always_comb
  begin
    sync1_d = mfi_wire_i;
    sync2_d = sync1_q;
    res_d   = resolved;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= ITSM_RST_WORD;
      sync2_q <= ITSM_RST_WORD;
      res_q   <= ITSM_RST_WORD;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      res_q   <= res_d;
    end
  end

  assign mfi_state_o = res_q;

endmodule

//--- common/itsm_pkg.sv
package itsm_pkg;

  // Data width of each terminal word.
  localparam int ITSM_DW = 16;

  // Wishbone byte address width; a register index sits above two byte bits.
  localparam int ITSM_AW      = 18;
  localparam int ITSM_ADR_LSB = 2;
  localparam int ITSM_BUS_DW  = 32;
  localparam int ITSM_LANES   = 2;
  localparam int ITSM_LANE_W  = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] ITSM_IDX_MASK  = 16'h024A;
  localparam logic [15:0] ITSM_IDX_STATE = 16'h024B;
  localparam logic [15:0] ITSM_IDX_POL   = 16'h024C;
  localparam logic [15:0] ITSM_IDX_RES   = 16'h024D;
  localparam logic [15:0] ITSM_IDX_WIRE  = 16'h024E;

  // Terminals one to seven on bits zero to six, ten to twelve on ten to 12.
  localparam logic [ITSM_DW-1:0] ITSM_USED_BITS = 16'h1C7F;

  // Factory default of every stored word.
  localparam logic [ITSM_DW-1:0] ITSM_RST_WORD = 16'h0000;
  localparam logic [ITSM_BUS_DW-ITSM_DW-1:0] ITSM_PAD = 16'h0000;

  // One write request to the internal-state word from a secondary writer.
  typedef struct packed {
    logic               wr;
    logic [ITSM_DW-1:0] data;
  } itsm_req_t;

  // The two words that are kept over power loss.
  typedef struct packed {
    logic [ITSM_DW-1:0] mask;
    logic [ITSM_DW-1:0] state;
  } itsm_words_t;

  // Restore sequencer of the retained words.
  typedef enum logic {
    ITSM_NV_WAIT = 1'b0,
    ITSM_NV_RUN  = 1'b1
  } itsm_nv_state_t;

  // Byte-lane merge of a bus write into a 16-bit register.
  function automatic logic [ITSM_DW-1:0] itsm_merge(
    input logic [ITSM_DW-1:0]    old_v,
    input logic [ITSM_DW-1:0]    new_v,
    input logic [ITSM_LANES-1:0] sel
  );
    logic [ITSM_DW-1:0] r;
    r = old_v;
    for (int l = 0; l < ITSM_LANES; l++)
    begin
      if (sel[l])
      begin
        r[l*ITSM_LANE_W +: ITSM_LANE_W] = new_v[l*ITSM_LANE_W +: ITSM_LANE_W];
      end
    end
    return r;
  endfunction

endpackage

//--- hdl/itsm_wb_slave.sv
module itsm_wb_slave
  import itsm_pkg::*;
(
  input  wire logic                   clk_i,      // System clock.
  input  wire logic                   rst_i,      // Synchronous reset.
  input  wire logic [ITSM_AW-1:0]     wb_adr_i,   // Byte address.
  input  wire logic [ITSM_BUS_DW-1:0] wb_dat_i,   // Write data.
  input  wire logic [3:0]             wb_sel_i,   // Byte enables.
  input  wire logic                   wb_we_i,    // Write enable.
  input  wire logic                   wb_cyc_i,   // Cycle.
  input  wire logic                   wb_stb_i,   // Strobe.
  output logic                        wb_ack_o,   // Acknowledge.
  output logic [ITSM_BUS_DW-1:0]      wb_dat_o,   // Read data.
  input  wire logic [ITSM_DW-1:0]     rd_word_i,  // Word at reg_idx_o.
  output logic [15:0]                 reg_idx_o,  // Register index.
  output logic                        reg_wr_o,   // Write strobe.
  output logic [ITSM_DW-1:0]          reg_wdat_o, // Write data.
  output logic [ITSM_LANES-1:0]       reg_sel_o   // Lane enables.
);

  logic                   ack_q;
  logic                   ack_d;
  logic [ITSM_BUS_DW-1:0] dat_q;
  logic [ITSM_BUS_DW-1:0] dat_d;
  logic                   take;

  // A request is taken once; ack then drops so a held strobe is not doubled.
  assign take       = wb_cyc_i & wb_stb_i & ~ack_q;
  assign reg_idx_o  = wb_adr_i[ITSM_AW-1:ITSM_ADR_LSB];
  assign reg_wr_o   = take & wb_we_i;
  assign reg_wdat_o = wb_dat_i[ITSM_DW-1:0];
  assign reg_sel_o  = wb_sel_i[ITSM_LANES-1:0];

  always_comb
  begin
    ack_d = take;
    dat_d = dat_q;
    if (take & ~wb_we_i)
    begin
      dat_d = {ITSM_PAD, rd_word_i};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule

//--- hdl/itsm_nvstore.sv
module itsm_nvstore
  import itsm_pkg::*;
(
  input  wire logic         clk_i,       // System clock.
  input  wire logic         rst_i,       // Synchronous reset.
  input  wire logic         nv_ready_i,  // Retained words are valid.
  input  itsm_words_t       nv_words_i,  // Retained words from storage.
  input  itsm_words_t       cur_words_i, // Live register contents.
  output logic              restore_o,   // One-cycle load pulse.
  output itsm_words_t       load_words_o,// Words to load.
  output logic              nv_save_o,   // One-cycle save pulse.
  output itsm_words_t       nv_words_o   // Words to save.
);

  itsm_nv_state_t st_q;
  itsm_nv_state_t st_d;
  logic           rest_q;
  logic           rest_d;
  logic           save_q;
  logic           save_d;
  itsm_words_t    load_q;
  itsm_words_t    load_d;
  itsm_words_t    last_q;
  itsm_words_t    last_d;
  itsm_words_t    out_q;
  itsm_words_t    out_d;

  always_comb
  begin
    st_d   = st_q;
    rest_d = 1'b0;
    save_d = 1'b0;
    load_d = load_q;
    last_d = last_q;
    out_d  = out_q;
    unique case (st_q)
      ITSM_NV_WAIT:
      begin
        if (nv_ready_i)
        begin
          rest_d = 1'b1;
          load_d = nv_words_i;
          last_d = nv_words_i;
          // Storage already holds these words, so show them as last saved.
          out_d  = nv_words_i;
          st_d   = ITSM_NV_RUN;
        end
      end
      ITSM_NV_RUN:
      begin
        // The registers load one cycle after the pulse, so skip that cycle.
        if (!rest_q && cur_words_i != last_q)
        begin
          save_d = 1'b1;
          out_d  = cur_words_i;
          last_d = cur_words_i;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= ITSM_NV_WAIT;
      rest_q <= 1'b0;
      save_q <= 1'b0;
      load_q <= '0;
      last_q <= '0;
      out_q  <= '0;
    end
    else
    begin
      st_q   <= st_d;
      rest_q <= rest_d;
      save_q <= save_d;
      load_q <= load_d;
      last_q <= last_d;
      out_q  <= out_d;
    end
  end

  assign restore_o    = rest_q;
  assign load_words_o = load_q;
  assign nv_save_o    = save_q;
  assign nv_words_o   = out_q;

endmodule

//--- bench/itsm_far_model.sv
module itsm_far_model
  import itsm_pkg::*;
(
  input  wire logic  clk_i,      // Clock.
  input  wire logic  rst_i,      // Reset.
  input  wire logic  nv_save_i,  // Save pulse.
  input  itsm_words_t nv_words_i, // Words to keep.
  output logic       nv_ready_o, // Words valid.
  output itsm_words_t nv_words_o  // Kept words.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  wait_q = 2'h0;
  itsm_words_t mem_q  = '0;
  // Storage comes up late after reset and shows junk until then.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wait_q <= 2'h0;
    else if (wait_q != 2'h3)
      wait_q <= wait_q + 2'h1;
    if (nv_save_i)
      mem_q <= nv_words_i;
  end
  assign nv_ready_o = (wait_q == 2'h3);
  assign nv_words_o = nv_ready_o ? mem_q : ~mem_q;
endmodule

//--- bench/itsm_top_properties.sv
module itsm_checker
  import itsm_pkg::*;
(
  input  wire logic [0:0]  clk_i,        // Clock.
  input  wire logic        rst_i,        // Reset.
  input  wire logic [17:0] wb_adr_i,     // Address.
  input  wire logic [31:0] wb_dat_i,     // Write data.
  input  wire logic [3:0]  wb_sel_i,     // Lanes.
  input  wire logic        wb_we_i,      // Write.
  input  wire logic        wb_cyc_i,     // Cycle.
  input  wire logic        wb_stb_i,     // Strobe.
  input  wire logic        wb_ack_o,     // Ack.
  input  wire logic [31:0] wb_dat_o,     // Read data.
  input  wire logic [15:0] mfi_wire_i,   // Wires.
  input  itsm_req_t        comm_req_i,   // Comm write.
  input  itsm_req_t        keypad_req_i, // Keypad write.
  input  wire logic [15:0] ctrl_own_i,   // Owned.
  input  wire logic [15:0] ctrl_level_i, // Owned level.
  input  wire logic        nv_ready_i,   // Kept valid.
  input  itsm_words_t      nv_words_i,   // Kept words.
  input  wire logic        nv_save_o,    // Save.
  input  itsm_words_t      nv_words_o,   // Saved words.
  input  wire logic [15:0] mfi_state_o   // Terminals.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] rdy_q;
  logic       req;
  // Gates checks until the restore has landed, since it overrides writes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdy_q <= 2'h0;
    else if (nv_ready_i && rdy_q != 2'h3)
      rdy_q <= rdy_q + 2'h1;
  end
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_latency_a: assert property (req |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  read_upper_a: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == ITSM_PAD)
    else $error("upper read bits set");
  unused_bits_a: assert property (
    (mfi_state_o & ~ITSM_USED_BITS) == '0)
    else $error("unused terminal set");
  reset_clear_a: assert property (
    $fell(rst_i) |-> !wb_ack_o && !nv_save_o && mfi_state_o == '0)
    else $error("not clear after reset");
  save_change_a: assert property (
    nv_save_o |-> nv_words_o != $past(nv_words_o))
    else $error("save without change");
  unmapped_read_a: assert property (
    req && !wb_we_i && wb_adr_i[17:2] < ITSM_IDX_MASK |=> wb_dat_o == '0)
    else $error("unmapped read not zero");
  mask_save_a: assert property (
    req && wb_we_i && wb_sel_i[1:0] == 2'h3
    && wb_adr_i[17:2] == ITSM_IDX_MASK && rdy_q == 2'h3
    |-> ##3 nv_words_o.mask == $past(wb_dat_i[15:0], 3))
    else $error("mask not saved");
  state_prio_a: assert property (
    comm_req_i.wr && keypad_req_i.wr && !req && rdy_q == 2'h3
    |-> ##3 nv_words_o.state == $past(comm_req_i.data, 3))
    else $error("keypad beat comm");
endmodule
bind itsm_top itsm_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .mfi_wire_i(mfi_wire_i),
  .comm_req_i(comm_req_i), .keypad_req_i(keypad_req_i),
  .ctrl_own_i(ctrl_own_i), .ctrl_level_i(ctrl_level_i),
  .nv_ready_i(nv_ready_i), .nv_words_i(nv_words_i), .nv_save_o(nv_save_o),
  .nv_words_o(nv_words_o), .mfi_state_o(mfi_state_o));

//--- bench/test_input_terminal_source_mux.sv
module test_input_terminal_source_mux
  import itsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [17:0] adr = '0;
  logic [31:0] dat = '0;
  logic [3:0]  sel = 4'h0;
  logic        ack;
  logic [31:0] rdat;
  logic [15:0] wire_v = '0;
  logic [15:0] own = '0;
  logic [15:0] lvl = '0;
  logic [15:0] mfi;
  itsm_req_t   comm = '0;
  itsm_req_t   key = '0;
  logic        nv_rdy;
  logic        save;
  itsm_words_t nv_in;
  itsm_words_t nv_out;
  int          error_cnt = 0;
  int          samples_checked = 0;

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  itsm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .wb_dat_o(rdat), .mfi_wire_i(wire_v),
    .comm_req_i(comm), .keypad_req_i(key), .ctrl_own_i(own),
    .ctrl_level_i(lvl), .nv_ready_i(nv_rdy), .nv_words_i(nv_in),
    .nv_save_o(save), .nv_words_o(nv_out), .mfi_state_o(mfi));
  itsm_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .nv_save_i(save),
    .nv_words_i(nv_out), .nv_ready_o(nv_rdy), .nv_words_o(nv_in));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [15:0] d, input logic [3:0] s,
                     output logic [15:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {idx, 2'b00};
    dat <= {ITSM_PAD, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d,
                    input logic [3:0] s);
    logic [15:0] q;
    bus(1'b1, idx, d, s, q);
  endtask

  task automatic rd(input string nm, input logic [15:0] idx,
                    input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, 4'h3, q);
    chk(nm, e, q);
  endtask

  // Wire changes need three edges, so four covers every path.
  task automatic look(input logic [15:0] e);
    repeat (4) @(posedge clk_i);
    chk("terminals", e, mfi);
  endtask

  task automatic do_reset();
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  initial
  begin
    do_reset();
    wire_v <= 16'hFFFF;
    rd("mask", ITSM_IDX_MASK, 16'h0000);
    rd("state", ITSM_IDX_STATE, 16'h0000);
    look(16'h1C7F);
    rd("wire", ITSM_IDX_WIRE, 16'h1C7F);
    wr(ITSM_IDX_MASK, 16'hFFFF, 4'h3);
    rd("mask", ITSM_IDX_MASK, 16'hFFFF);
    look(16'h0000);
    wr(ITSM_IDX_STATE, 16'h0034, 4'h3);
    look(16'h0034);
    wr(ITSM_IDX_POL, 16'h0005, 4'h3);
    look(16'h0031);
    wr(ITSM_IDX_POL, 16'h0000, 4'h3);
    wr(ITSM_IDX_MASK, 16'h0000, 4'h3);
    wire_v <= 16'h0000;
    own <= 16'h0042;
    lvl <= 16'h0040;
    wr(ITSM_IDX_STATE, 16'h0002, 4'h3);
    look(16'h0042);
    comm <= '{1'b1, 16'h0400};
    key <= '{1'b1, 16'h1000};
    @(posedge clk_i);
    comm.wr <= 1'b0;
    key.wr <= 1'b0;
    rd("state", ITSM_IDX_STATE, 16'h0400);
    key <= '{1'b1, 16'h1000};
    @(posedge clk_i);
    key.wr <= 1'b0;
    rd("state", ITSM_IDX_STATE, 16'h1000);
    rd("unmapped", 16'h0100, 16'h0000);
    wr(ITSM_IDX_POL, 16'hABCD, 4'h2);
    rd("polarity", ITSM_IDX_POL, 16'hAB00);
    wr(ITSM_IDX_RES, 16'hFFFF, 4'h3);
    rd("resolved", ITSM_IDX_RES, 16'h0040);
    wr(ITSM_IDX_MASK, 16'h1C00, 4'h3);
    do_reset();
    rd("mask", ITSM_IDX_MASK, 16'h1C00);
    rd("state", ITSM_IDX_STATE, 16'h1000);
    tally_and_finish();
  end
endmodule
